// [include/mqs_pkg.sv]
// Constants and types for the multi-queue port switching block
// Operation
// RULE_01: Read queue chosen by address with strobe
// RULE_02: Reads stay on selected queue until changed
// RULE_03: Read accepted every edge, even select edge
// RULE_04: Controller waits four cycles for new data
// RULE_05: No read when strobe high or empty
// RULE_06: Output drive gates bus, not register load
// RULE_07: Queue select: upper device, low queue bits
// RULE_08: Flag strobe picks empty flag group
// RULE_09: Packets at least four widest words
// RULE_10: Almost-empty bus becomes packet ready bus
// RULE_11: Packet writes go old queue two edges
// RULE_12: Full flag shows new queue second edge
// RULE_13: New queue writes from third edge
// RULE_14: No write into a full queue
// RULE_15: Packet reads old queue two edges if driven
// RULE_16: Expansion only in standard flag mode
// RULE_17: Chip code must match upper address bits
// RULE_18: Write flag strobe picks full flag group
// RULE_19: Write queue chosen by address with strobe
// RULE_20: New switch accepted every four cycles
// RULE_21: Writes continue to current queue during switch
// RULE_22: Mode straps sampled at configuration
// RULE_23: Empty flag low means selected queue empty
// RULE_24: Flags update third cycle, reads fourth
// RULE_25: Select during busy switch is ignored
// RULE_26: Reset selects queue zero, all empty
package mqs_pkg;
  localparam int MQS_DATA_W   = 36;  // Widest word
  localparam int MQS_QUEUES   = 32;  // Queues per device
  localparam int MQS_DEPTH    = 4;   // Words per queue
  localparam int MQS_ADDR_W   = 8;   // Address bus width
  localparam int MQS_QSEL_W   = 5;   // Queue field width
  localparam int MQS_DEV_W    = 3;   // Chip code width
  localparam int MQS_DEV_LSB  = 5;   // Device field position
  localparam int MQS_GRP_W    = 2;   // Status word field used
  localparam int MQS_FLAG_W   = 8;   // Flag bus width
  localparam int MQS_AE_LEVEL = 1;   // Almost-empty at or below
  localparam int MQS_AF_LEVEL = 1;   // Almost-full within this
  localparam int MQS_SW_CYCLES = 4;  // Cycles per switch

  // Switch sequence, one-hot
  typedef enum logic [3:0] {
    SW_IDLE = 4'b0001,
    SW_QS0  = 4'b0010,
    SW_QS1  = 4'b0100,
    SW_QS2  = 4'b1000
  } mqs_sw_type;
endpackage : mqs_pkg

// [verilog/mqs_switch.sv]
// Multi-queue buffer with write and read port queue switching
`timescale 1ns/1ps
module mqs_switch #(
  parameter int DATA_W = mqs_pkg::MQS_DATA_W,
  parameter int DEPTH  = mqs_pkg::MQS_DEPTH
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  input  wire logic                           packet_mode_pin,
  input  wire logic                           fall_through_select,
  input  wire logic [mqs_pkg::MQS_DEV_W-1:0]  chip_select_code,
  input  wire logic [mqs_pkg::MQS_ADDR_W-1:0] write_queue_addr,
  input  wire logic                           write_addr_strobe,
  input  wire logic                           write_flag_strobe,
  input  wire logic                           write_strobe_n,
  input  wire logic [DATA_W-1:0]              write_data,
  input  wire logic                           tx_packet_start,
  input  wire logic                           tx_packet_end,
  output logic                                queue_full_n,
  output logic [mqs_pkg::MQS_FLAG_W-1:0]      almost_full_n,
  input  wire logic [mqs_pkg::MQS_ADDR_W-1:0] read_queue_addr,
  input  wire logic                           read_addr_strobe,
  input  wire logic                           read_flag_strobe,
  input  wire logic                           read_strobe_n,
  input  wire logic                           output_drive_n,
  output logic [DATA_W-1:0]                   read_data_bus,
  output logic                                read_data_oe,
  output logic                                rx_packet_start,
  output logic                                rx_packet_end,
  output logic                                queue_empty_n,
  output logic [mqs_pkg::MQS_FLAG_W-1:0]      almost_empty_n
);
  import mqs_pkg::*;

  localparam int PW = $clog2(DEPTH);   // Pointer width
  localparam int CW = PW + 1;          // Count width
  localparam int QW = MQS_QSEL_W;
  localparam int GW = MQS_GRP_W;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] AE_CNT = CW'(MQS_AE_LEVEL);
  localparam logic [CW-1:0] AF_CNT = CW'(DEPTH - MQS_AF_LEVEL);

  // Storage: word plus start and end markers
  logic [DATA_W+1:0] mem    [MQS_QUEUES*DEPTH];
  logic [PW-1:0]     wp_r   [MQS_QUEUES];   // Write pointers
  logic [PW-1:0]     rp_r   [MQS_QUEUES];   // Read pointers
  logic [CW-1:0]     cnt_r  [MQS_QUEUES];   // Words held
  logic [CW-1:0]     pkt_r  [MQS_QUEUES];   // Whole packets held

  logic              pkt_mode_r;            // Packet operation
  logic              fall_through_select_r;                // Fall-through flags
  logic [MQS_DEV_W-1:0] dev_r;              // Captured chip code
  mqs_sw_type        wsw_r;                 // Write switch state
  mqs_sw_type        rsw_r;                 // Read switch state
  logic [QW-1:0]     wq_r;                  // Write present queue
  logic [QW-1:0]     wnext_r;               // Write next queue
  logic [QW-1:0]     rq_r;                  // Read present queue
  logic [QW-1:0]     rnext_r;               // Read next queue
  logic [GW-1:0]     wgrp_r;                // Full flag group
  logic [GW-1:0]     rgrp_r;                // Empty flag group
  logic              full_n_r;
  logic              empty_n_r;
  logic [MQS_FLAG_W-1:0] af_n_r;
  logic [MQS_FLAG_W-1:0] ae_n_r;
  logic [DATA_W-1:0] rdata_r;               // Output register
  logic              rx_packet_start_r;
  logic              rx_packet_end_r;

  logic              wacc;                  // Write switch taken
  logic              racc;                  // Read switch taken
  logic              wfacc;                 // Full group select
  logic              rfacc;                 // Empty group select
  logic              wr_en;
  logic              rd_en;
  logic              rd_hold;               // Packet old-queue edges
  logic [DATA_W+1:0] rd_word;
  logic [QW-1:0]     wflq;                  // Queue behind full flag
  logic [QW-1:0]     rflq;                  // Queue behind empty flag

  // Device select; in fall-through no expansion, so no compare
  function automatic logic addr_hit(
    input logic [MQS_ADDR_W-1:0] a,
    input logic [MQS_DEV_W-1:0]  dev,
    input logic                  ft
  );
    addr_hit = ft || (a[MQS_ADDR_W-1:MQS_DEV_LSB] == dev); // [RULE_16]
  endfunction : addr_hit

  // Flat memory index of a queue slot
  function automatic logic [QW+PW-1:0] slot(
    input logic [QW-1:0] q,
    input logic [PW-1:0] p
  );
    slot = {q, p};
  endfunction : slot

  // Straps caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pkt_mode_r <= packet_mode_pin;       // [RULE_22]
      fall_through_select_r     <= fall_through_select;   // [RULE_22]
      dev_r      <= chip_select_code;      // [RULE_17]
    end
  end

  // Request decode; a busy port ignores new queue selects but still takes flag group selects
  always_comb begin
    wacc  = write_addr_strobe && !write_flag_strobe &&
            addr_hit(write_queue_addr, dev_r, fall_through_select_r) &&
            (wsw_r == SW_IDLE);            // [RULE_19] [RULE_25]
    racc  = read_addr_strobe && !read_flag_strobe &&
            addr_hit(read_queue_addr, dev_r, fall_through_select_r) &&
            (rsw_r == SW_IDLE);            // [RULE_01] [RULE_07]
    wfacc = write_flag_strobe && !write_addr_strobe &&
            addr_hit(write_queue_addr, dev_r, fall_through_select_r); // [RULE_18]
    rfacc = read_flag_strobe && !read_addr_strobe &&
            addr_hit(read_queue_addr, dev_r, fall_through_select_r);  // [RULE_08]
  end

  // Write gating: full blocks, packet mode gaps at QS1
  always_comb begin
    wr_en = !write_strobe_n && (cnt_r[wq_r] != FULL_CNT) &&
            !(pkt_mode_r && wsw_r == SW_QS1); // [RULE_14] [RULE_11]
  end

  // Read gating; in standard mode reads run on every edge, even a select edge
  always_comb begin
    rd_hold = pkt_mode_r && (racc || rsw_r == SW_QS0);
    rd_en   = !read_strobe_n && (cnt_r[rq_r] != '0) &&
              !(rd_hold && output_drive_n) &&
              !(pkt_mode_r && rsw_r == SW_QS1); // [RULE_05] [RULE_15]
    rd_word = mem[slot(rq_r, rp_r[rq_r])];      // [RULE_02] [RULE_03]
  end

  // Flags look at the next queue from QS1 onward
  always_comb begin
    wflq = (wsw_r == SW_QS1) ? wnext_r : wq_r;
    rflq = (rsw_r == SW_QS1) ? rnext_r : rq_r;
  end

  // Write switch sequence: one switch per four cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wsw_r   <= SW_IDLE;
      wq_r    <= '0;                       // [RULE_26]
      wnext_r <= '0;
    end else begin
      case (wsw_r)
        SW_IDLE: begin
          if (wacc) begin
            wnext_r <= write_queue_addr[QW-1:0]; // [RULE_19]
            wsw_r   <= SW_QS0;             // [RULE_20]
          end
        end
        SW_QS0: begin
          wsw_r <= SW_QS1;                 // [RULE_21]
        end
        SW_QS1: begin
          wq_r  <= wnext_r;                // [RULE_13]
          wsw_r <= SW_QS2;
        end
        SW_QS2: begin
          wsw_r <= SW_IDLE;                // [RULE_20]
        end
        default: begin
          wsw_r <= SW_IDLE;
        end
      endcase
    end
  end

  // Read switch sequence, same shape as the write side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsw_r   <= SW_IDLE;
      rq_r    <= '0;                       // [RULE_26]
      rnext_r <= '0;
    end else begin
      case (rsw_r)
        SW_IDLE: begin
          if (racc) begin
            rnext_r <= read_queue_addr[QW-1:0]; // [RULE_01]
            rsw_r   <= SW_QS0;
          end
        end
        SW_QS0: begin
          rsw_r <= SW_QS1;
        end
        SW_QS1: begin
          rq_r  <= rnext_r;                // [RULE_24]
          rsw_r <= SW_QS2;
        end
        SW_QS2: begin
          rsw_r <= SW_IDLE;
        end
        default: begin
          rsw_r <= SW_IDLE;
        end
      endcase
    end
  end

  // Data storage; no reset needed on the array itself
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[slot(wq_r, wp_r[wq_r])] <=
        {tx_packet_start, tx_packet_end, write_data};
    end
  end

  // Pointers and counts; a same-queue write and read cancel
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < MQS_QUEUES; i++) begin
      if (rst) begin
        wp_r[i]  <= '0;
        rp_r[i]  <= '0;
        cnt_r[i] <= '0;                    // [RULE_26]
        pkt_r[i] <= '0;
      end else begin
        if (wr_en && wq_r == QW'(i))
          wp_r[i] <= wp_r[i] + 1'b1;
        if (rd_en && rq_r == QW'(i))
          rp_r[i] <= rp_r[i] + 1'b1;
        cnt_r[i] <= cnt_r[i]
                    + CW'(wr_en && wq_r == QW'(i))
                    - CW'(rd_en && rq_r == QW'(i));
        pkt_r[i] <= pkt_r[i]
                    + CW'(wr_en && tx_packet_end && wq_r == QW'(i))
                    - CW'(rd_en && rd_word[DATA_W] &&
                          rq_r == QW'(i));
      end
    end
  end

  // Output register loads whatever the output drive level, except on packet-mode select and QS0 edges, which need drive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= '0;
      rx_packet_start_r  <= 1'b0;
      rx_packet_end_r  <= 1'b0;
    end else if (rd_en) begin
      rdata_r <= rd_word[DATA_W-1:0];      // [RULE_06]
      rx_packet_start_r  <= rd_word[DATA_W+1];
      rx_packet_end_r  <= rd_word[DATA_W];
    end
  end

  // Flag group selects from the strobed status address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wgrp_r <= '0;
      rgrp_r <= '0;
    end else begin
      if (wfacc)
        wgrp_r <= write_queue_addr[GW-1:0]; // [RULE_18]
      if (rfacc)
        rgrp_r <= read_queue_addr[GW-1:0];  // [RULE_08]
    end
  end

  // Discrete flags; one cycle behind the counts by design
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_n_r  <= 1'b1;
      empty_n_r <= fall_through_select;    // [RULE_26]
    end else begin
      full_n_r  <= (cnt_r[wflq] != FULL_CNT); // [RULE_12]
      // Fall-through: low means a word is ready
      empty_n_r <= fall_through_select_r ? (cnt_r[rflq] == '0)
                          : (cnt_r[rflq] != '0); // [RULE_23]
    end
  end

  // Flag buses; packet mode turns almost-empty into ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      af_n_r <= '1;
      ae_n_r <= '0;                        // [RULE_26]
    end else begin
      for (int i = 0; i < MQS_FLAG_W; i++) begin
        af_n_r[i] <= !(cnt_r[{wgrp_r, 3'(i)}] >= AF_CNT);
        if (pkt_mode_r)
          ae_n_r[i] <= (pkt_r[{rgrp_r, 3'(i)}] == '0); // [RULE_10]
        else
          ae_n_r[i] <= !(cnt_r[{rgrp_r, 3'(i)}] <= AE_CNT);
      end
    end
  end

  // Port drive
  always_comb begin
    read_data_bus   = rdata_r;
    read_data_oe    = !output_drive_n;     // [RULE_06]
    rx_packet_start = rx_packet_start_r;
    rx_packet_end   = rx_packet_end_r;
    queue_full_n    = full_n_r;
    queue_empty_n   = empty_n_r;
    almost_full_n   = af_n_r;
    almost_empty_n  = ae_n_r;
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_no_full_write;
    wr_en |-> cnt_r[wq_r] < FULL_CNT;
  endproperty
  a_no_full_write: assert property (p_no_full_write) // [RULE_14]
    else $error("write into full queue");

  property p_no_empty_read;
    rd_en |-> !read_strobe_n && cnt_r[rq_r] != '0;
  endproperty
  a_no_empty_read: assert property (p_no_empty_read) // [RULE_05]
    else $error("read while idle or empty");

  property p_read_select;
    racc |=> rnext_r == $past(read_queue_addr[QW-1:0])
             ##2 rq_r == $past(read_queue_addr[QW-1:0], 3);
  endproperty
  a_read_select: assert property (p_read_select) // [RULE_01]
    else $error("read queue not taken");

  property p_write_switch;
    wacc |=> (wq_r == $past(wq_r)) ##1 (wq_r == $past(wq_r, 2))
             ##1 (wq_r == wnext_r);
  endproperty
  a_write_switch: assert property (p_write_switch) // [RULE_13]
    else $error("write queue changed off schedule");

  property p_full_new_queue;
    wsw_r == SW_QS1 |=> queue_full_n ==
                        ($past(cnt_r[wnext_r]) != FULL_CNT);
  endproperty
  a_full_new_queue: assert property (p_full_new_queue) // [RULE_12]
    else $error("full flag not for new queue");

  property p_switch_period;
    wacc |=> !wacc [*3] ##1 (wsw_r == SW_IDLE);
  endproperty
  a_switch_period: assert property (p_switch_period) // [RULE_20]
    else $error("switch period not four cycles");

  property p_busy_ignored;
    (rsw_r != SW_IDLE) && read_addr_strobe |=>
      $stable(rnext_r);
  endproperty
  a_busy_ignored: assert property (p_busy_ignored) // [RULE_25]
    else $error("busy read select not ignored");

  // Old queue pointer must not move on the packet gap edge
  property p_packet_gap;
    pkt_mode_r && wsw_r == SW_QS1 |=>
      wp_r[$past(wq_r)] == $past(wp_r[wq_r]);
  endproperty
  a_packet_gap: assert property (p_packet_gap) // [RULE_11]
    else $error("packet write in switch gap");

  property p_load_undriven;
    rd_en && output_drive_n |-> !read_data_oe ##1
      read_data_bus == $past(rd_word[DATA_W-1:0]);
  endproperty
  a_load_undriven: assert property (p_load_undriven) // [RULE_06]
    else $error("output register not loaded");

  property p_read_switch;
    rsw_r == SW_QS1 |=> rq_r == $past(rnext_r) && rsw_r == SW_QS2;
  endproperty
  a_read_switch: assert property (p_read_switch) // [RULE_24]
    else $error("read queue not switched at third cycle");

  cover property (wacc ##4 wr_en);
  cover property (racc ##4 rd_en);
  cover property (pkt_mode_r && racc && rd_en);
  cover property (!write_strobe_n && !wr_en);
endmodule : mqs_switch

// [tb/mqs_bus_model.sv]
// Shared read data bus as the controller sees it
`timescale 1ns/1ps
module mqs_bus_model #(
  parameter int DATA_W = mqs_pkg::MQS_DATA_W  // Word width
) (
  input  wire logic              sys_clk,
  input  wire logic [DATA_W-1:0] read_data_bus,
  input  wire logic              read_data_oe,
  output logic      [DATA_W-1:0] bus_seen
);
  import mqs_pkg::*;
  logic [DATA_W-1:0] last_r;  // Last word seen while driven
  // Remember the driven word for the released bus
  always_ff @(posedge sys_clk) begin
    if (read_data_oe) begin
      last_r <= read_data_bus;
    end
  end
  // Released bus shows the inverse, so a stale word never matches
  assign bus_seen = read_data_oe ? read_data_bus : ~last_r;
endmodule : mqs_bus_model

// [tb/test_mqs_switch.sv]
// Self-checking bench for the queue switching block
`timescale 1ns/1ps
module test_mqs_switch;
  import mqs_pkg::*;
  localparam int DP = 8;           // Shallow queues keep fills short
  localparam int DW = MQS_DATA_W;  // Word width
  logic                  sys_clk, rst, packet_mode_pin, fall_through_select;
  logic [MQS_DEV_W-1:0]  chip_select_code;
  logic [MQS_ADDR_W-1:0] write_queue_addr, read_queue_addr;
  logic                  write_addr_strobe, write_flag_strobe;
  logic                  write_strobe_n, tx_packet_start, tx_packet_end;
  logic [DW-1:0]         write_data, read_data_bus, bus_seen;
  logic                  queue_full_n, read_addr_strobe, read_flag_strobe;
  logic                  read_strobe_n, output_drive_n, read_data_oe;
  logic                  rx_packet_start, rx_packet_end, queue_empty_n;
  logic [MQS_FLAG_W-1:0] almost_full_n, almost_empty_n;
  logic                  wf, rf, dn, sp, ep;  // Modal inputs held by bench
  int                    miscompares, comparisons;

  mqs_switch #(.DATA_W(DW), .DEPTH(DP)) mqs_switch_inst (
    .sys_clk(sys_clk), .rst(rst), .packet_mode_pin(packet_mode_pin),
    .fall_through_select(fall_through_select),
    .chip_select_code(chip_select_code),
    .write_queue_addr(write_queue_addr),
    .write_addr_strobe(write_addr_strobe),
    .write_flag_strobe(write_flag_strobe),
    .write_strobe_n(write_strobe_n), .write_data(write_data),
    .tx_packet_start(tx_packet_start), .tx_packet_end(tx_packet_end),
    .queue_full_n(queue_full_n), .almost_full_n(almost_full_n),
    .read_queue_addr(read_queue_addr),
    .read_addr_strobe(read_addr_strobe),
    .read_flag_strobe(read_flag_strobe), .read_strobe_n(read_strobe_n),
    .output_drive_n(output_drive_n), .read_data_bus(read_data_bus),
    .read_data_oe(read_data_oe), .rx_packet_start(rx_packet_start),
    .rx_packet_end(rx_packet_end), .queue_empty_n(queue_empty_n),
    .almost_empty_n(almost_empty_n)
  );

  mqs_bus_model #(.DATA_W(DW)) mqs_bus_model_inst (
    .sys_clk(sys_clk), .read_data_bus(read_data_bus),
    .read_data_oe(read_data_oe), .bus_seen(bus_seen)
  );

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // One comparison, reported at once on mismatch
  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Every input set once per cycle, so no signal is driven twice
  task put(input logic ws, input logic [7:0] wa, input logic wn,
           input logic [DW-1:0] wd, input logic rs, input logic [7:0] ra,
           input logic rn);
    write_addr_strobe <= ws;
    write_queue_addr <= wa;
    write_strobe_n <= wn;
    write_data <= wd;
    read_addr_strobe <= rs;
    read_queue_addr <= ra;
    read_strobe_n <= rn;
    write_flag_strobe <= wf;
    read_flag_strobe <= rf;
    output_drive_n <= dn;
    tx_packet_start <= sp;
    tx_packet_end <= ep;
  endtask : put

  // One clock cycle of requests, taken at the following edge
  task cyc(input logic ws, input logic [7:0] wa, input logic wn,
           input logic [DW-1:0] wd, input logic rs, input logic [7:0] ra,
           input logic rn);
    @(posedge sys_clk);
    put(ws, wa, wn, wd, rs, ra, rn);
  endtask : cyc

  task idle;
    cyc(1'b0, 8'h00, 1'b1, 36'h0, 1'b0, 8'h00, 1'b1);
  endtask : idle

  task wr(input logic [DW-1:0] d);
    cyc(1'b0, 8'h00, 1'b0, d, 1'b0, 8'h00, 1'b1);
  endtask : wr

  // Issue a read cycle and check the word of the previous request
  task rd(input logic rs, input logic [7:0] ra, input logic rn,
          input logic [DW-1:0] exp);
    cyc(1'b0, 8'h00, 1'b1, 36'h0, rs, ra, rn);
    @(negedge sys_clk);
    chk(read_data_bus, exp);
  endtask : rd

  // Flag group select, bus checked once settled
  task fg(input logic w, input logic [7:0] a, input logic [7:0] exp);
    wf = w;
    rf = !w;
    cyc(1'b0, a, 1'b1, 36'h0, 1'b0, a, 1'b1);
    wf = 1'b0;
    rf = 1'b0;
    idle;
    idle;
    @(negedge sys_clk);
    chk(36'(w ? almost_full_n : almost_empty_n), 36'(exp));
  endtask : fg

  // Reset with the given straps, then the reset state
  task reset_dut(input logic pkt, input logic ft);
    @(posedge sys_clk);
    rst <= 1'b1;
    packet_mode_pin <= pkt;
    fall_through_select <= ft;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(36'(queue_empty_n), 36'(ft));
    chk(36'(queue_full_n), 36'h1);
    chk(36'(almost_full_n), 36'hff);
    chk(36'(almost_empty_n), 36'h0);
    chk(read_data_bus, 36'h0);
  endtask : reset_dut

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end

  initial begin
    miscompares = 0;
    comparisons = 0;
    {wf, rf, dn, sp, ep} = 5'h0;
    rst <= 1'b1;
    chip_select_code <= 3'h2;
    put(1'b0, 8'h00, 1'b1, 36'h0, 1'b0, 8'h00, 1'b1);
    for (int m = 3; m >= 0; m--) begin
      reset_dut(m[1], m[0]);
    end
    // Write port: foreign device code, then a switch hit by a late select
    cyc(1'b1, 8'ha7, 1'b0, 36'h0c0, 1'b0, 8'h00, 1'b1);
    idle;
    idle;
    wr(36'h0c1);
    cyc(1'b1, 8'h43, 1'b0, 36'h0a0, 1'b0, 8'h00, 1'b1);
    cyc(1'b1, 8'h49, 1'b0, 36'h0a1, 1'b0, 8'h00, 1'b1);
    wr(36'h0a2);
    for (int i = 0; i <= DP; i++) begin
      wr(36'h0b0 + 36'(i));
    end
    idle;
    idle;
    @(negedge sys_clk);
    chk(36'(queue_full_n), 36'h0);
    chk(36'(almost_full_n), 36'hf7);
    // Back to queue 0: full flag follows on the second edge
    cyc(1'b1, 8'h40, 1'b1, 36'h0, 1'b0, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      idle;
      @(negedge sys_clk);
      chk(36'(queue_full_n), 36'(i == 2));
    end
    fg(1'b1, 8'h41, 8'hff);
    fg(1'b1, 8'h40, 8'hf7);
    fg(1'b0, 8'h43, 8'h00);
    fg(1'b0, 8'h40, 8'h09);
    // Read port: old queue drains for three edges, new one from the fourth
    rd(1'b1, 8'h43, 1'b0, 36'h0);
    rd(1'b1, 8'h49, 1'b0, 36'h0c0);
    rd(1'b0, 8'h00, 1'b0, 36'h0c1);
    dn = 1'b1;
    rd(1'b0, 8'h00, 1'b0, 36'h0a0);
    chk(36'(read_data_oe), 36'h0);
    dn = 1'b0;
    rd(1'b0, 8'h00, 1'b0, 36'h0b0);
    chk(bus_seen, 36'h0b0);
    for (int i = 1; i < DP; i++) begin
      rd(1'b0, 8'h00, 1'b0, 36'h0b0 + 36'(i));
    end
    rd(1'b0, 8'h00, 1'b1, 36'h0b7);
    chk(36'(queue_empty_n), 36'h0);
    rd(1'b1, 8'h40, 1'b1, 36'h0b7);
    for (int i = 0; i < 3; i++) begin
      rd(1'b0, 8'h00, 1'(i != 2), 36'h0b7);
      chk(36'(queue_empty_n), 36'(i == 2));
    end
    rd(1'b0, 8'h00, 1'b0, 36'h0a1);
    rd(1'b0, 8'h00, 1'b1, 36'h0a2);
    // Packet mode: one packet, then a write switch with a dropped word
    reset_dut(1'b1, 1'b0);
    sp = 1'b1;
    wr(36'h0d0);
    sp = 1'b0;
    wr(36'h0d1);
    wr(36'h0d2);
    ep = 1'b1;
    wr(36'h0d3);
    ep = 1'b0;
    cyc(1'b1, 8'h41, 1'b0, 36'h0e0, 1'b0, 8'h00, 1'b1);
    wr(36'h0e1);
    wr(36'h0e2);
    wr(36'h0e3);
    idle;
    idle;
    @(negedge sys_clk);
    chk(36'(almost_empty_n), 36'hfe);
    chk(36'(queue_empty_n), 36'h1);
    rd(1'b0, 8'h00, 1'b0, 36'h0);
    rd(1'b0, 8'h00, 1'b0, 36'h0d0);
    chk(36'(rx_packet_start), 36'h1);
    rd(1'b0, 8'h00, 1'b0, 36'h0d1);
    rd(1'b1, 8'h41, 1'b0, 36'h0d2);
    rd(1'b0, 8'h00, 1'b0, 36'h0d3);
    chk(36'(rx_packet_end), 36'h1);
    rd(1'b0, 8'h00, 1'b0, 36'h0e0);
    rd(1'b0, 8'h00, 1'b0, 36'h0e0);
    rd(1'b0, 8'h00, 1'b1, 36'h0e3);
    rd(1'b0, 8'h00, 1'b1, 36'h0e3);
    // Fall-through: foreign code still switches, low flag means data
    reset_dut(1'b0, 1'b1);
    cyc(1'b1, 8'ha5, 1'b1, 36'h0, 1'b0, 8'h00, 1'b1);
    idle;
    idle;
    wr(36'h0f0);
    rd(1'b1, 8'h45, 1'b1, 36'h0);
    for (int i = 0; i < 3; i++) begin
      rd(1'b0, 8'h00, 1'(i != 2), 36'h0);
    end
    chk(36'(queue_empty_n), 36'h0);
    rd(1'b0, 8'h00, 1'b1, 36'h0f0);
    stop_test;
  end
endmodule : test_mqs_switch
